// ---- logic/pcx_perf_counters.sv ----
`timescale 1ns/1ps
`default_nettype none

module pcx_perf_counters (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic measure_en,
    input wire logic count_clear,
    input wire logic chain_en,
    input wire pcx_pkg::pcx_opt_t opt_a,
    input wire pcx_pkg::pcx_opt_t opt_b,
    input wire logic [pcx_pkg::RATIO_W-1:0] bus_ratio,
    input wire pcx_pkg::pcx_cpu_ev_t cpu_ev,
    input wire pcx_pkg::pcx_sbus_t sbus_in,
    input wire logic ratio_start,
    output logic [pcx_pkg::CNT_W-1:0] ch_a_q,
    output logic [pcx_pkg::CNT_W-1:0] ch_b_q,
    output logic ch_a_ovf_q,
    output logic ch_b_ovf_q,
    output logic [pcx_pkg::NCNT-1:0][pcx_pkg::CNT_W-1:0] metric_q,
    output logic [pcx_pkg::NCNT-1:0] metric_ovf_q,
    output logic [pcx_pkg::ELAPSED_W-1:0] elapsed_ns_q,
    output logic [pcx_pkg::CNT_W:0] insn_total_q,
    output logic [pcx_pkg::CNT_W-1:0] exc_total_q,
    output logic [pcx_pkg::CNT_W-1:0] fetch_total_q,
    output logic [pcx_pkg::CNT_W:0] operand_total_q,
    output logic [pcx_pkg::NRATIO-1:0][pcx_pkg::Q_W-1:0] ratio_q,
    output logic [pcx_pkg::NRATIO-1:0] ratio_den_zero_q,
    output logic ratio_busy_q,
    output logic ratio_done_q
);

    localparam int NC = pcx_pkg::NCNT;
    localparam int CW = pcx_pkg::CNT_W;
    localparam int DW = pcx_pkg::DIV_W;

    // adds an amount, returning carry and sum
    function automatic logic [CW:0] cnt_add(input logic [CW-1:0] cnt,
                                            input logic [CW-1:0] amt);
        cnt_add = {1'b0, cnt} + {1'b0, amt};
    endfunction : cnt_add

    // difference floored at zero, widened for the divider
    function automatic logic [DW-1:0] sub_floor(input logic [DW-1:0] a,
                                                 input logic [DW-1:0] b);
        sub_floor = (a > b) ? (a - b) : '0;
    endfunction : sub_floor

    // picks the event that a selectable channel counts
    function automatic logic sel_event(input pcx_pkg::pcx_opt_t opt,
                                       input pcx_pkg::pcx_cpu_ev_t ev,
                                       input pcx_pkg::pcx_bus_ev_t bev);
        case (opt)
            pcx_pkg::PCX_OPT_RD_WAIT: sel_event = ev.op_rd_wait;
            pcx_pkg::PCX_OPT_WR_WAIT: sel_event = ev.operand_write_wait_event;
            pcx_pkg::PCX_OPT_RD_MISS_WAIT: sel_event = ev.read_miss_wait_event
                                                     | ev.fill_contention_wait;
            pcx_pkg::PCX_OPT_WR_MISS_WAIT: sel_event = ev.write_miss_wait_event;
            pcx_pkg::PCX_OPT_REQ_CELL: sel_event = bev.bus_request_cell_event;
            pcx_pkg::PCX_OPT_RSP_CELL: sel_event = bev.bus_response_cell_event;
            pcx_pkg::PCX_OPT_REQ_STALL: sel_event = bev.request_stall_event;
            pcx_pkg::PCX_OPT_RSP_STALL: sel_event = bev.response_stall_event;
            default: sel_event = 1'b0;
        endcase
    endfunction : sel_event

    // system bus inputs cross into mclk through two flops
    pcx_pkg::pcx_sbus_t sbus_s1_q;
    pcx_pkg::pcx_sbus_t sbus_s2_q;
    logic sbus_clk_prev_q;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sbus_s1_q <= '0;
            sbus_s2_q <= '0;
            sbus_clk_prev_q <= 1'b0;
        end else begin
            sbus_s1_q <= sbus_in;
            sbus_s2_q <= sbus_s1_q;
            sbus_clk_prev_q <= sbus_s2_q.clk;
        end
    end

    // one tick per bus clock cycle, at its falling edge where bus lines are settled
    wire logic bus_tick = sbus_clk_prev_q & ~sbus_s2_q.clk;
    wire logic req_wait_any = |(sbus_s2_q.req & ~sbus_s2_q.gnt);
    wire logic rsp_wait_any = |(sbus_s2_q.r_req & ~sbus_s2_q.r_gnt);
    pcx_pkg::pcx_bus_ev_t bus_ev;

    assign bus_ev.bus_request_cell_event = bus_tick & sbus_s2_q.req_cell;
    assign bus_ev.bus_response_cell_event = bus_tick & sbus_s2_q.rsp_cell;
    assign bus_ev.request_stall_event = bus_tick & req_wait_any;
    assign bus_ev.response_stall_event = bus_tick & rsp_wait_any;

    // selectable channels
    wire logic ev_a = measure_en & sel_event(opt_a, cpu_ev, bus_ev);
    wire logic ev_b = measure_en & sel_event(opt_b, cpu_ev, bus_ev);
    wire logic [CW:0] ch_a_sum = cnt_add(ch_a_q, {{(CW-1){1'b0}}, ev_a});
    wire logic ch_a_carry = ch_a_sum[CW];
    wire logic ch_b_inc = chain_en ? ch_a_carry : ev_b;
    wire logic [CW:0] ch_b_sum = cnt_add(ch_b_q, {{(CW-1){1'b0}}, ch_b_inc});
    wire logic ch_a_wrap = ch_a_carry & ~chain_en;

    // dedicated metric counters and their increments
    logic [NC-1:0][CW-1:0] cnt_amt;
    logic [NC-1:0][CW:0] cnt_sum;
    wire logic [CW-1:0] req_amt = {{(CW-pcx_pkg::RATIO_W){1'b0}}, bus_ratio};

    assign cnt_amt[pcx_pkg::IDX_ELAPSED] = {{(CW-1){1'b0}}, measure_en};
    assign cnt_amt[pcx_pkg::IDX_INSN] = {{(CW-1){1'b0}}, measure_en & cpu_ev.insn_valid};
    assign cnt_amt[pcx_pkg::IDX_DUAL] = {{(CW-1){1'b0}}, measure_en & cpu_ev.dual_issue};
    assign cnt_amt[pcx_pkg::IDX_EXC] = {{(CW-1){1'b0}}, measure_en & cpu_ev.exc_accept};
    assign cnt_amt[pcx_pkg::IDX_OPC] = {{(CW-1){1'b0}}, measure_en & cpu_ev.opcode_access};
    assign cnt_amt[pcx_pkg::IDX_IC_ACC] = {{(CW-1){1'b0}}, measure_en & cpu_ev.ic_access};
    assign cnt_amt[pcx_pkg::IDX_IC_MISS] = {{(CW-1){1'b0}}, measure_en & cpu_ev.ic_miss};
    assign cnt_amt[pcx_pkg::IDX_OP_RD] = {{(CW-1){1'b0}}, measure_en & cpu_ev.op_rd_access};
    assign cnt_amt[pcx_pkg::IDX_OP_WR] = {{(CW-1){1'b0}}, measure_en & cpu_ev.op_wr_access};
    assign cnt_amt[pcx_pkg::IDX_OC_RD] = {{(CW-1){1'b0}}, measure_en & cpu_ev.oc_rd_access};
    assign cnt_amt[pcx_pkg::IDX_OC_WR] = {{(CW-1){1'b0}}, measure_en & cpu_ev.oc_wr_access};
    assign cnt_amt[pcx_pkg::IDX_OCM_RD] = {{(CW-1){1'b0}}, measure_en & cpu_ev.oc_rd_miss};
    assign cnt_amt[pcx_pkg::IDX_OCM_WR] = {{(CW-1){1'b0}}, measure_en & cpu_ev.oc_wr_miss};
    // each request cell is worth bus_ratio cpu clocks
    assign cnt_amt[pcx_pkg::IDX_REQ_EQV] = (measure_en & bus_ev.bus_request_cell_event)
                                           ? req_amt : pcx_pkg::CNT_RST;

    genvar gi;
    generate
        for (gi = 0; gi < NC; gi++) begin : g_sum
            assign cnt_sum[gi] = cnt_add(metric_q[gi], cnt_amt[gi]);
        end
    endgenerate

    // all counting on mclk, so a stopped cpu clock freezes every count
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ch_a_q <= pcx_pkg::CNT_RST;
            ch_b_q <= pcx_pkg::CNT_RST;
            ch_a_ovf_q <= 1'b0;
            ch_b_ovf_q <= 1'b0;
        end else begin
            ch_a_q <= count_clear ? pcx_pkg::CNT_RST : ch_a_sum[CW-1:0];
            ch_b_q <= count_clear ? pcx_pkg::CNT_RST : ch_b_sum[CW-1:0];
            ch_a_ovf_q <= ch_a_wrap | (ch_a_ovf_q & ~count_clear);
            ch_b_ovf_q <= ch_b_sum[CW] | (ch_b_ovf_q & ~count_clear);
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            metric_q <= '0;
            metric_ovf_q <= '0;
        end else begin
            for (int i = 0; i < NC; i++) begin
                metric_q[i] <= count_clear ? pcx_pkg::CNT_RST : cnt_sum[i][CW-1:0];
                metric_ovf_q[i] <= cnt_sum[i][CW] | (metric_ovf_q[i] & ~count_clear);
            end
        end
    end

    // derived metrics
    wire logic [pcx_pkg::ELAPSED_W-1:0] elapsed_ext = {{CW{1'b0}}, metric_q[pcx_pkg::IDX_ELAPSED]};
    wire logic [pcx_pkg::ELAPSED_W-1:0] period_ext = pcx_pkg::ELAPSED_W'(pcx_pkg::CLK_PERIOD_NS);
    wire logic [pcx_pkg::ELAPSED_W-1:0] elapsed_ns_d = elapsed_ext * period_ext;
    wire logic [CW:0] insn_total_d = cnt_add(metric_q[pcx_pkg::IDX_INSN],
                                             metric_q[pcx_pkg::IDX_DUAL]);
    wire logic [CW:0] operand_total_d = cnt_add(metric_q[pcx_pkg::IDX_OP_RD],
                                                metric_q[pcx_pkg::IDX_OP_WR]);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            elapsed_ns_q <= '0;
            insn_total_q <= '0;
            exc_total_q <= pcx_pkg::CNT_RST;
            fetch_total_q <= pcx_pkg::CNT_RST;
            operand_total_q <= '0;
        end else begin
            elapsed_ns_q <= elapsed_ns_d;
            insn_total_q <= insn_total_d;
            exc_total_q <= metric_q[pcx_pkg::IDX_EXC];
            fetch_total_q <= metric_q[pcx_pkg::IDX_OPC];
            operand_total_q <= operand_total_d;
        end
    end

    // hit ratio operands, widened to the divider width
    wire logic [DW-1:0] ic_acc = {1'b0, metric_q[pcx_pkg::IDX_IC_ACC]};
    wire logic [DW-1:0] ic_miss = {1'b0, metric_q[pcx_pkg::IDX_IC_MISS]};
    wire logic [DW-1:0] ocr_acc = {1'b0, metric_q[pcx_pkg::IDX_OC_RD]};
    wire logic [DW-1:0] ocw_acc = {1'b0, metric_q[pcx_pkg::IDX_OC_WR]};
    wire logic [DW-1:0] ocr_miss = {1'b0, metric_q[pcx_pkg::IDX_OCM_RD]};
    wire logic [DW-1:0] ocw_miss = {1'b0, metric_q[pcx_pkg::IDX_OCM_WR]};
    wire logic [DW-1:0] oc_acc_all = ocr_acc + ocw_acc;
    wire logic [DW-1:0] oc_miss_all = ocr_miss + ocw_miss;

    logic [pcx_pkg::NRATIO-1:0][DW-1:0] rat_num;
    logic [pcx_pkg::NRATIO-1:0][DW-1:0] rat_den;

    assign rat_num[pcx_pkg::RAT_IC] = sub_floor(ic_acc, ic_miss);
    assign rat_den[pcx_pkg::RAT_IC] = ic_acc;
    assign rat_num[pcx_pkg::RAT_OC_RD] = sub_floor(ocr_acc, ocr_miss);
    assign rat_den[pcx_pkg::RAT_OC_RD] = ocr_acc;
    assign rat_num[pcx_pkg::RAT_OC_WR] = sub_floor(ocw_acc, ocw_miss);
    assign rat_den[pcx_pkg::RAT_OC_WR] = ocw_acc;
    assign rat_num[pcx_pkg::RAT_OC_ALL] = sub_floor(oc_acc_all, oc_miss_all);
    assign rat_den[pcx_pkg::RAT_OC_ALL] = oc_acc_all;
    assign rat_num[pcx_pkg::RAT_BUS_OCC] = {1'b0, metric_q[pcx_pkg::IDX_REQ_EQV]};
    assign rat_den[pcx_pkg::RAT_BUS_OCC] = {1'b0, metric_q[pcx_pkg::IDX_ELAPSED]};

    // all dividers start together; each takes the same number of cycles, except that one with a zero denominator goes straight to done
    logic [pcx_pkg::NRATIO-1:0] div_busy;
    logic [pcx_pkg::NRATIO-1:0] div_done;

    generate
        for (gi = 0; gi < pcx_pkg::NRATIO; gi++) begin : g_div
            pcx_ratio_div u_div (
                .mclk(mclk),
                .reset_n(reset_n),
                .start(ratio_start),
                .num(rat_num[gi]),
                .den(rat_den[gi]),
                .quot_q(ratio_q[gi]),
                .den_zero_q(ratio_den_zero_q[gi]),
                .busy_q(div_busy[gi]),
                .done_q(div_done[gi])
            );
        end
    endgenerate

    assign ratio_busy_q = div_busy[0];
    assign ratio_done_q = div_done[0];

endmodule : pcx_perf_counters

`default_nettype wire

// ---- common/pcx_pkg.sv ----
package pcx_pkg;

    localparam int CNT_W = 32;
    localparam int NREQ = 4;
    localparam int RATIO_W = 4;
    localparam int DIV_W = 33;
    localparam int FRAC_W = 16;
    localparam int Q_W = FRAC_W + 1;
    localparam int STEP_W = 5;
    localparam int NRATIO = 5;

    // cpu clock period, used to turn elapsed cycles into elapsed time
    localparam int CLK_PERIOD_NS = 25;
    localparam int MCLK_HZ = 40000000;
    localparam int ELAPSED_W = 2 * CNT_W;

    localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
    localparam logic [STEP_W-1:0] DIV_STEPS = 5'h10;

    // dedicated metric counter indices
    localparam int IDX_ELAPSED = 0;
    localparam int IDX_INSN = 1;
    localparam int IDX_DUAL = 2;
    localparam int IDX_EXC = 3;
    localparam int IDX_OPC = 4;
    localparam int IDX_IC_ACC = 5;
    localparam int IDX_IC_MISS = 6;
    localparam int IDX_OP_RD = 7;
    localparam int IDX_OP_WR = 8;
    localparam int IDX_OC_RD = 9;
    localparam int IDX_OC_WR = 10;
    localparam int IDX_OCM_RD = 11;
    localparam int IDX_OCM_WR = 12;
    localparam int IDX_REQ_EQV = 13;
    localparam int NCNT = 14;

    // ratio slots
    localparam int RAT_IC = 0;
    localparam int RAT_OC_RD = 1;
    localparam int RAT_OC_WR = 2;
    localparam int RAT_OC_ALL = 3;
    localparam int RAT_BUS_OCC = 4;

    typedef enum logic [3:0] {
        PCX_OPT_NONE = 4'h0,
        PCX_OPT_RD_WAIT = 4'h1,
        PCX_OPT_WR_WAIT = 4'h2,
        PCX_OPT_RD_MISS_WAIT = 4'h3,
        PCX_OPT_WR_MISS_WAIT = 4'h4,
        PCX_OPT_REQ_CELL = 4'h5,
        PCX_OPT_RSP_CELL = 4'h6,
        PCX_OPT_REQ_STALL = 4'h7,
        PCX_OPT_RSP_STALL = 4'h8
    } pcx_opt_t;

    typedef struct packed {
        logic insn_valid;
        logic dual_issue;
        logic exc_accept;
        logic opcode_access;
        logic ic_access;
        logic ic_miss;
        logic op_rd_access;
        logic op_wr_access;
        logic oc_rd_access;
        logic oc_wr_access;
        logic oc_rd_miss;
        logic oc_wr_miss;
        logic op_rd_wait;
        logic operand_write_wait_event;
        logic read_miss_wait_event;
        logic fill_contention_wait;
        logic write_miss_wait_event;
    } pcx_cpu_ev_t;

    typedef struct packed {
        logic clk;
        logic req_cell;
        logic rsp_cell;
        logic [NREQ-1:0] req;
        logic [NREQ-1:0] gnt;
        logic [NREQ-1:0] r_req;
        logic [NREQ-1:0] r_gnt;
    } pcx_sbus_t;

    typedef struct packed {
        logic bus_request_cell_event;
        logic bus_response_cell_event;
        logic request_stall_event;
        logic response_stall_event;
    } pcx_bus_ev_t;

endpackage : pcx_pkg

// ---- logic/pcx_ratio_div.sv ----
`timescale 1ns/1ps
`default_nettype none

module pcx_ratio_div (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [pcx_pkg::DIV_W-1:0] num,
    input wire logic [pcx_pkg::DIV_W-1:0] den,
    output logic [pcx_pkg::Q_W-1:0] quot_q,
    output logic den_zero_q,
    output logic busy_q,
    output logic done_q
);

    typedef enum logic [2:0] {
        DIV_IDLE = 3'h1,
        DIV_RUN = 3'h2,
        DIV_DONE = 3'h4
    } pcx_div_st_t;

    pcx_div_st_t state_q;
    logic [pcx_pkg::DIV_W:0] rem_q;
    logic [pcx_pkg::DIV_W-1:0] den_q;
    logic [pcx_pkg::STEP_W-1:0] step_q;

    // hit count cannot exceed accesses; clamp so the quotient stays within 1.0
    wire logic [pcx_pkg::DIV_W-1:0] num_clamp = (num > den) ? den : num;
    wire logic take = rem_q >= {1'b0, den_q};
    wire logic [pcx_pkg::DIV_W:0] rem_sub = rem_q - {1'b0, den_q};
    wire logic [pcx_pkg::DIV_W:0] rem_next = take ? {rem_sub[pcx_pkg::DIV_W-1:0], 1'b0}
                                                   : {rem_q[pcx_pkg::DIV_W-1:0], 1'b0};

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_q <= DIV_IDLE;
            rem_q <= '0;
            den_q <= '0;
            step_q <= '0;
            quot_q <= '0;
            den_zero_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            unique case (state_q)
                DIV_IDLE: begin
                    if (start) begin
                        rem_q <= {1'b0, num_clamp};
                        den_q <= den;
                        quot_q <= '0;
                        step_q <= pcx_pkg::DIV_STEPS;
                        den_zero_q <= (den == '0);
                        busy_q <= 1'b1;
                        state_q <= (den == '0) ? DIV_DONE : DIV_RUN;
                    end
                end
                DIV_RUN: begin
                    rem_q <= rem_next;
                    quot_q <= {quot_q[pcx_pkg::Q_W-2:0], take};
                    step_q <= step_q - 5'h01;
                    if (step_q == '0) begin
                        state_q <= DIV_DONE;
                    end
                end
                DIV_DONE: begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    state_q <= DIV_IDLE;
                end
            endcase
        end
    end

endmodule : pcx_ratio_div

`default_nettype wire

// ---- bench/pcx_perf_counters_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

module pcx_perf_asserts (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic measure_en,
    input wire logic count_clear,
    input wire logic chain_en,
    input wire pcx_pkg::pcx_opt_t opt_a,
    input wire pcx_pkg::pcx_opt_t opt_b,
    input wire pcx_pkg::pcx_cpu_ev_t cpu_ev,
    input wire logic [pcx_pkg::CNT_W-1:0] ch_a_q,
    input wire logic [pcx_pkg::CNT_W-1:0] ch_b_q,
    input wire logic [pcx_pkg::NCNT-1:0][pcx_pkg::CNT_W-1:0] metric_q,
    input wire logic [pcx_pkg::ELAPSED_W-1:0] elapsed_ns_q,
    input wire logic [pcx_pkg::CNT_W:0] insn_total_q,
    input wire logic [pcx_pkg::CNT_W-1:0] exc_total_q,
    input wire logic [pcx_pkg::CNT_W:0] operand_total_q
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    chk_read_wait: assert property (
        measure_en && !count_clear && opt_a == pcx_pkg::PCX_OPT_RD_WAIT
        |=> ch_a_q == $past(ch_a_q) + {31'h0, $past(cpu_ev.op_rd_wait)})
        else $error("read wait channel count wrong");
    chk_write_wait: assert property (
        measure_en && !count_clear && !chain_en && opt_b == pcx_pkg::PCX_OPT_WR_WAIT
        |-> ##1 ch_b_q == $past(ch_b_q) + {31'h0, $past(cpu_ev.operand_write_wait_event)})
        else $error("write wait channel count wrong");
    chk_read_miss: assert property (
        measure_en && !count_clear && opt_a == pcx_pkg::PCX_OPT_RD_MISS_WAIT
        |=> ch_a_q - $past(ch_a_q) ==
            {31'h0, $past(cpu_ev.read_miss_wait_event | cpu_ev.fill_contention_wait)})
        else $error("read miss wait channel count wrong");
    chk_write_miss: assert property (
        measure_en && !count_clear && !chain_en && opt_b == pcx_pkg::PCX_OPT_WR_MISS_WAIT
        |=> ch_b_q == $past(ch_b_q) + {31'h0, $past(cpu_ev.write_miss_wait_event)})
        else $error("write miss wait channel count wrong");
    chk_elapsed_time: assert property (
        1'h1 |=> elapsed_ns_q == {32'h0, $past(metric_q[0])} * 64'h19)
        else $error("elapsed time not cycles times period");
    chk_insn_total: assert property (
        1'h1 |=> insn_total_q == {1'h0, $past(metric_q[1])} + {1'h0, $past(metric_q[2])})
        else $error("instruction total wrong");
    chk_exc_total: assert property (
        1'h1 |=> exc_total_q == $past(metric_q[3]))
        else $error("accepted interrupt total wrong");
    chk_operand_sum: assert property (
        1'h1 |=> operand_total_q == {1'h0, $past(metric_q[7])} + {1'h0, $past(metric_q[8])})
        else $error("operand access total wrong");
endmodule : pcx_perf_asserts

bind pcx_perf_counters pcx_perf_asserts pcx_perf_asserts_inst (
    .mclk, .reset_n, .measure_en, .count_clear, .chain_en, .opt_a, .opt_b, .cpu_ev,
    .ch_a_q, .ch_b_q, .metric_q, .elapsed_ns_q, .insn_total_q, .exc_total_q,
    .operand_total_q
);

`default_nettype wire

// ---- bench/pcx_sbus_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module pcx_sbus_model (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic start,
    input wire logic [3:0] lag,
    input wire logic [3:0] mask,
    output var pcx_pkg::pcx_sbus_t sbus,
    output var logic busy
);
    // burst of eight bus cycles at mclk/8; the bus clock stands low between bursts
    int ph;
    int k;
    always @(posedge mclk) begin
        if (!reset_n) begin
            sbus <= '0;
            busy <= 1'h0;
            ph <= 0;
            k <= 0;
        end else if (!busy) begin
            busy <= start;
            ph <= 0;
            k <= 0;
        end else begin
            ph <= (ph + 1) % 8;
            if (ph == 0) begin
                // lines move with the rising bus clock, steady over the falling half
                sbus.clk <= 1'h1;
                sbus.req_cell <= 1'h1;
                sbus.rsp_cell <= k[0];
                sbus.req <= mask;
                sbus.gnt <= (k >= lag) ? mask : 4'h0;
                sbus.r_req <= mask;
                sbus.r_gnt <= (k > lag) ? mask : 4'h0;
            end
            if (ph == 4) begin
                sbus.clk <= 1'h0;
            end
            if (ph == 7) begin
                k <= k + 1;
            end
            if (ph == 7 && k == 7) begin
                busy <= 1'h0;
                // released lines do not keep their last value
                sbus <= {1'h0, ~sbus[$bits(sbus)-2:0]};
            end
        end
    end
endmodule : pcx_sbus_model

`default_nettype wire

// ---- bench/pcx_perf_counters_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module pcx_perf_counters_test;
    logic mclk = 1'h0, reset_n = 1'h0, measure_en = 1'h0, count_clear = 1'h0;
    logic chain_en = 1'h0, ratio_start = 1'h0, sb_start = 1'h0, sb_busy, ratio_done_q;
    logic ch_a_ovf_q, ch_b_ovf_q, ratio_busy_q;
    logic [pcx_pkg::NCNT-1:0] metric_ovf_q;
    pcx_pkg::pcx_opt_t opt_a = pcx_pkg::PCX_OPT_NONE, opt_b = pcx_pkg::PCX_OPT_NONE;
    // the bus model runs one bus clock per eight mclk
    logic [3:0] bus_ratio = 4'h8, sb_lag = 4'h0;
    pcx_pkg::pcx_cpu_ev_t cpu_ev = '0;
    pcx_pkg::pcx_sbus_t sbus_in;
    logic [31:0] ch_a_q, ch_b_q, exc_total_q, fetch_total_q;
    logic [32:0] insn_total_q, operand_total_q;
    logic [63:0] elapsed_ns_q;
    logic [pcx_pkg::NCNT-1:0][31:0] metric_q;
    logic [pcx_pkg::NRATIO-1:0][pcx_pkg::Q_W-1:0] ratio_q;
    logic [pcx_pkg::NRATIO-1:0] ratio_den_zero_q;
    int n_fail = 0, checked = 0;

    pcx_perf_counters pcx_perf_counters_inst (
        .mclk, .reset_n, .measure_en, .count_clear, .chain_en, .opt_a, .opt_b, .bus_ratio,
        .cpu_ev, .sbus_in, .ratio_start, .ch_a_q, .ch_b_q, .ch_a_ovf_q, .ch_b_ovf_q,
        .metric_q, .metric_ovf_q, .elapsed_ns_q, .insn_total_q, .exc_total_q,
        .fetch_total_q, .operand_total_q, .ratio_q, .ratio_den_zero_q, .ratio_busy_q,
        .ratio_done_q
    );
    pcx_sbus_model pcx_sbus_model_inst (
        .mclk, .reset_n, .start(sb_start), .lag(sb_lag), .mask(4'h7), .sbus(sbus_in),
        .busy(sb_busy)
    );

    initial begin
        forever #12.5 mclk = ~mclk;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    task automatic clr();
        @(posedge mclk);
        count_clear <= 1'h1;
        @(posedge mclk);
        count_clear <= 1'h0;
    endtask : clr

    task automatic go();
        @(posedge mclk);
        ratio_start <= 1'h1;
        @(posedge mclk);
        ratio_start <= 1'h0;
        @(negedge mclk);
        chk("ratio_busy", 1, ratio_busy_q);
        for (int i = 0; i < 40 && ratio_done_q !== 1'h1; i++) begin
            @(negedge mclk);
        end
        chk("ratio_done", 1, ratio_done_q);
        @(negedge mclk);
    endtask : go

    task automatic t_den_zero();
        clr();
        go();
        chk("den_zero", 31, ratio_den_zero_q);
        chk("ratio_ic", 0, ratio_q[0]);
    endtask : t_den_zero

    // event bit i is high for i+1 cycles, then two cycles of fill contention only
    task automatic t_events(input int o);
        int ex[5] = '{0, 5, 4, 5, 1};
        clr();
        opt_a <= pcx_pkg::pcx_opt_t'(o);
        opt_b <= pcx_pkg::pcx_opt_t'(o % 4 + 1);
        cpu_ev <= '1;
        @(posedge mclk);
        for (int c = 0; c < 19; c++) begin
            measure_en <= 1'h1;
            cpu_ev <= pcx_pkg::pcx_cpu_ev_t'((c < 17) ? 17'h1FFFF << c : 17'h2);
            @(posedge mclk);
        end
        measure_en <= 1'h0;
        cpu_ev <= '0;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk("ch_a", ex[o], ch_a_q);
        chk("ch_b", ex[o % 4 + 1], ch_b_q);
        for (int k = 1; k <= 12; k++) begin
            chk("metric", 18 - k, metric_q[k]);
        end
        chk("elapsed", 19, metric_q[0]);
        chk("elapsed_ns", 475, elapsed_ns_q);
        chk("insn_total", 33, insn_total_q);
        chk("exc_total", 15, exc_total_q);
        chk("fetch_total", 14, fetch_total_q);
        chk("operand_total", 21, operand_total_q);
        chk("ovf_flags", 0, {ch_a_ovf_q, ch_b_ovf_q, metric_ovf_q});
    endtask : t_events

    // chained: ch_b counts only ch_a wraps, never its own selected event
    task automatic t_chain();
        clr();
        chain_en <= 1'h1;
        opt_a <= pcx_pkg::PCX_OPT_RD_WAIT;
        opt_b <= pcx_pkg::PCX_OPT_WR_WAIT;
        cpu_ev <= pcx_pkg::pcx_cpu_ev_t'(17'h00018);
        measure_en <= 1'h1;
        repeat (3) @(posedge mclk);
        measure_en <= 1'h0;
        cpu_ev <= '0;
        chain_en <= 1'h0;
        @(negedge mclk);
        chk("chain_a", 3, ch_a_q);
        chk("chain_b", 0, ch_b_q);
        chk("chain_ovf", 0, {ch_a_ovf_q, ch_b_ovf_q});
    endtask : t_chain

    task automatic t_ratio();
        pcx_pkg::pcx_cpu_ev_t e;
        clr();
        for (int c = 0; c < 4; c++) begin
            e = '0;
            e.ic_access = 1'h1;
            e.ic_miss = (c == 0);
            e.oc_rd_access = 1'h1;
            e.oc_rd_miss = (c < 2);
            e.oc_wr_access = 1'h1;
            measure_en <= 1'h1;
            cpu_ev <= e;
            @(posedge mclk);
        end
        measure_en <= 1'h0;
        cpu_ev <= '0;
        go();
        chk("ratio_ic", 17'h0C000, ratio_q[0]);
        chk("ratio_oc_rd", 17'h08000, ratio_q[1]);
        chk("ratio_oc_wr", 17'h10000, ratio_q[2]);
        chk("ratio_oc_all", 17'h0C000, ratio_q[3]);
        chk("ratio_bus", 0, ratio_q[4]);
    endtask : t_ratio

    // three requests wait together: each stalled bus cycle must add one
    task automatic t_bus(input int lag);
        for (int p = 0; p < 2; p++) begin
            clr();
            opt_a <= p ? pcx_pkg::PCX_OPT_RSP_CELL : pcx_pkg::PCX_OPT_REQ_CELL;
            opt_b <= p ? pcx_pkg::PCX_OPT_RSP_STALL : pcx_pkg::PCX_OPT_REQ_STALL;
            measure_en <= 1'h1;
            sb_lag <= 4'(lag);
            sb_start <= 1'h1;
            @(posedge mclk);
            sb_start <= 1'h0;
            @(negedge mclk);
            for (int i = 0; i < 200 && sb_busy === 1'h1; i++) begin
                @(negedge mclk);
            end
            repeat (6) @(posedge mclk);
            measure_en <= 1'h0;
            @(negedge mclk);
            chk("bus_cells", p ? 4 : 8, ch_a_q);
            chk("bus_stall", lag + p, ch_b_q);
            if (p == 0) begin
                chk("req_equiv", 64, metric_q[13]);
            end
        end
    endtask : t_bus

    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        conclude();
    end

    initial begin
        repeat (12) @(posedge mclk);
        reset_n <= 1'h1;
        t_den_zero();
        for (int o = 1; o <= 4; o++) begin
            t_events(o);
        end
        t_chain();
        t_ratio();
        t_bus(0);
        t_bus(3);
        conclude();
    end
endmodule : pcx_perf_counters_test

`default_nettype wire
